// >>> rtl/rrts_defs.svh
// timing counts, widths and reset values of the reset release block
// assumes a single 50 MHz system clock
`ifndef RRTS_DEFS_SVH
`define RRTS_DEFS_SVH

`define RRTS_CLK_PERIOD_NS   20
`define RRTS_SAMPLE_TIME_NS  1500
`define RRTS_SAMPLE_CYCLES   ((`RRTS_SAMPLE_TIME_NS + `RRTS_CLK_PERIOD_NS - 1) / `RRTS_CLK_PERIOD_NS)
`define RRTS_TP_WIDTH        8
`define RRTS_CNT_WIDTH       7
`define RRTS_TP_RESET        8'h00
`define RRTS_ST_HOLD         3'h1
`define RRTS_ST_WAIT         3'h2
`define RRTS_ST_RUN          3'h4

`endif

// >>> rtl/rrts_pkg.sv
// types of the reset release block
// assumes rrts_defs.svh on the include path
`include "rrts_defs.svh"
`default_nettype none

package rrts_pkg;
   typedef enum logic [2:0] {
      RRTS_HOLD = `RRTS_ST_HOLD,
      RRTS_WAIT = `RRTS_ST_WAIT,
      RRTS_RUN  = `RRTS_ST_RUN
   } rrts_state_t;
endpackage

`default_nettype wire

// >>> rtl/rrts_reset_release.sv
// power-on reset release, strap sampling and test-point pin control
// assumes pins are asynchronous to clk and testObs comes from clk logic
//
// Operation
// R1: rising edge on power-on reset pin starts self-configuration
// R2: reset source holds pin low until supplies and clocks are stable
// R3: while reset pin is low no output is in its active state
// R4: all eight test-point pins tristated while reset pin is low
// R5: about 1.5 us after release, test points sampled as test-mode strap
// R6: after sampling, test-point pins are driven as outputs
// R7: weak pull-down; a pin sampled high selects a test mode
// R8: board holds test-port reset low in normal operation
// R9: reset release synchronised to clk; strap delay counted on clk
`include "rrts_defs.svh"
`default_nettype none

module rrts_reset_release
   import rrts_pkg::*;
#(
   parameter int                    TP_W          = `RRTS_TP_WIDTH,
   parameter int                    CNT_W         = `RRTS_CNT_WIDTH,
   parameter logic [CNT_W-1:0]      SAMPLE_CYCLES = CNT_W'(`RRTS_SAMPLE_CYCLES)
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                powerOnResetN,
   input  wire logic                testPortResetN,
   input  wire logic [TP_W-1:0]     testPointIn,
   input  wire logic [TP_W-1:0]     testObs,
   output logic      [TP_W-1:0]     testPointOut,
   output logic      [TP_W-1:0]     testPointOe,
   output logic                     configStart,
   output logic                     configBusy,
   output logic      [TP_W-1:0]     testModeSel,
   output logic                     testModeActive,
   output logic                     testPortAlarm
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic              porSync1_reg;
   logic              porSync2_reg;
   logic              porSync3_reg;
   logic              porLevel_reg;
   logic              tprSync1_reg;
   logic              tprSync2_reg;
   logic              tprSync3_reg;
   logic              tprLevel_reg;
   logic [TP_W-1:0]   tpSync1_reg;
   logic [TP_W-1:0]   tpSync2_reg;
   logic [TP_W-1:0]   tpSync3_reg;
   logic              porRise;

   // R9 synchronised release
   always_ff @(posedge clk) begin
      if (rst) begin
         porSync1_reg <= 1'b0;
         porSync2_reg <= 1'b0;
         porSync3_reg <= 1'b0;
         porLevel_reg <= 1'b0;
      end else begin
         porSync1_reg <= powerOnResetN;
         porSync2_reg <= porSync1_reg;
         porSync3_reg <= porSync2_reg;
         if (porSync2_reg == porSync3_reg) begin
            porLevel_reg <= porSync3_reg;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tprSync1_reg <= 1'b0;
         tprSync2_reg <= 1'b0;
         tprSync3_reg <= 1'b0;
         tprLevel_reg <= 1'b0;
         tpSync1_reg  <= `RRTS_TP_RESET;
         tpSync2_reg  <= `RRTS_TP_RESET;
         tpSync3_reg  <= `RRTS_TP_RESET;
      end else begin
         tprSync1_reg <= testPortResetN;
         tprSync2_reg <= tprSync1_reg;
         tprSync3_reg <= tprSync2_reg;
         if (tprSync2_reg == tprSync3_reg) begin
            tprLevel_reg <= tprSync3_reg;
         end
         tpSync1_reg <= testPointIn;
         tpSync2_reg <= tpSync1_reg;
         tpSync3_reg <= tpSync2_reg;
      end
   end

   // R1 release edge
   assign porRise = !porLevel_reg && porSync2_reg && porSync3_reg;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   rrts_state_t       state_reg;
   logic [CNT_W-1:0]  count_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg      <= RRTS_HOLD;
         count_reg      <= '0;
         configStart    <= 1'b0;
         configBusy     <= 1'b0;
         testModeSel    <= `RRTS_TP_RESET;
         testModeActive <= 1'b0;
         testPointOe    <= `RRTS_TP_RESET;
         testPointOut   <= `RRTS_TP_RESET;
      end else begin
         configStart <= 1'b0;
         unique case (state_reg)
            RRTS_HOLD: begin
               // R4 pins released
               testPointOe    <= `RRTS_TP_RESET;
               testPointOut   <= `RRTS_TP_RESET;
               // R3 outputs quiet
               testModeSel    <= `RRTS_TP_RESET;
               testModeActive <= 1'b0;
               configBusy     <= 1'b0;
               count_reg      <= '0;
               // R1 start configuration
               if (porRise) begin
                  state_reg   <= RRTS_WAIT;
                  configStart <= 1'b1;
                  configBusy  <= 1'b1;
               end
            end
            RRTS_WAIT: begin
               if (!porLevel_reg) begin
                  state_reg  <= RRTS_HOLD;
                  configBusy <= 1'b0;
               // R5 strap sample point
               end else if (count_reg == SAMPLE_CYCLES - CNT_W'(1)) begin
                  state_reg      <= RRTS_RUN;
                  configBusy     <= 1'b0;
                  testModeSel    <= tpSync3_reg;
                  // R7 high strap selects test mode
                  testModeActive <= |tpSync3_reg;
                  // R6 turn pins to outputs
                  testPointOe    <= '1;
                  testPointOut   <= testObs;
               end else begin
                  count_reg <= count_reg + CNT_W'(1);
               end
            end
            RRTS_RUN: begin
               if (!porLevel_reg) begin
                  state_reg      <= RRTS_HOLD;
                  testPointOe    <= `RRTS_TP_RESET;
                  testPointOut   <= `RRTS_TP_RESET;
                  testModeSel    <= `RRTS_TP_RESET;
                  testModeActive <= 1'b0;
               end else begin
                  // R6 drive test outputs
                  testPointOut <= testObs;
               end
            end
         endcase
      end
   end

   // R8 flag test-port reset left high
   always_ff @(posedge clk) begin
      if (rst) begin
         testPortAlarm <= 1'b0;
      end else begin
         testPortAlarm <= porLevel_reg && tprLevel_reg;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_start_on_rise;
      @(posedge clk) disable iff (rst)
      (state_reg == RRTS_HOLD && porRise) |=> configStart && state_reg == RRTS_WAIT;
   endproperty
   a_start_on_rise: assert property (p_start_on_rise) // R1
      else $error("configuration did not start on reset release");

   property p_start_single;
      @(posedge clk) disable iff (rst)
      configStart |=> !configStart [*2];
   endproperty
   a_start_single: assert property (p_start_single) // R1
      else $error("configuration start longer than one cycle");

   property p_quiet_in_reset;
      @(posedge clk) disable iff (rst)
      (!porLevel_reg && !$past(porLevel_reg)) |->
         !testModeActive && testModeSel == '0 && !testPortAlarm && !configStart;
   endproperty
   a_quiet_in_reset: assert property (p_quiet_in_reset) // R3
      else $error("output active while reset pin low");

   property p_tristate;
      @(posedge clk) disable iff (rst)
      (state_reg != RRTS_RUN) |-> testPointOe == '0;
   endproperty
   a_tristate: assert property (p_tristate) // R4
      else $error("test points driven before sampling");

   property p_sample_delay;
      @(posedge clk) disable iff (rst)
      $rose(state_reg == RRTS_RUN) |->
         $past(count_reg) == SAMPLE_CYCLES - CNT_W'(1) && $past(state_reg) == RRTS_WAIT;
   endproperty
   a_sample_delay: assert property (p_sample_delay) // R5
      else $error("strap sampled at wrong delay");

   property p_strap_latched;
      @(posedge clk) disable iff (rst)
      $rose(state_reg == RRTS_RUN) |-> testModeSel == $past(tpSync3_reg);
   endproperty
   a_strap_latched: assert property (p_strap_latched) // R5
      else $error("strap value not captured");

   property p_drive_after;
      @(posedge clk) disable iff (rst)
      (state_reg == RRTS_RUN) |-> testPointOe == '1;
   endproperty
   a_drive_after: assert property (p_drive_after) // R6
      else $error("test points not driven after sampling");

   property p_out_follows;
      @(posedge clk) disable iff (rst)
      (state_reg == RRTS_RUN && $past(state_reg) == RRTS_RUN && $past(porLevel_reg))
         |-> testPointOut == $past(testObs);
   endproperty
   a_out_follows: assert property (p_out_follows) // R6
      else $error("test point output does not follow observation data");

   property p_mode_flag;
      @(posedge clk) disable iff (rst)
      testModeActive == (testModeSel != '0);
   endproperty
   a_mode_flag: assert property (p_mode_flag) // R7
      else $error("test mode flag disagrees with strap");

   property p_sync_release;
      @(posedge clk) disable iff (rst)
      $rose(porLevel_reg) |-> $past(porSync2_reg) && $past(porSync3_reg);
   endproperty
   a_sync_release: assert property (p_sync_release) // R9
      else $error("release taken without filter agreement");

   property p_alarm;
      @(posedge clk) disable iff (rst)
      (porLevel_reg && tprLevel_reg) |=> testPortAlarm;
   endproperty
   a_alarm: assert property (p_alarm) // R8
      else $error("test-port reset high not flagged");

   c_reach_run: cover property (@(posedge clk) disable iff (rst)
      $rose(state_reg == RRTS_RUN));
   c_test_mode: cover property (@(posedge clk) disable iff (rst) $rose(testModeActive));
   c_abort_wait: cover property (@(posedge clk) disable iff (rst)
      state_reg == RRTS_WAIT && !porLevel_reg);
   c_alarm: cover property (@(posedge clk) disable iff (rst) $rose(testPortAlarm));

endmodule // rrts_reset_release

`default_nettype wire

// >>> tb/rrts_power_model.sv
// power manager and board strap model facing the reset release block
// assumes one clock; tb requests releases and chooses pull-ups
`default_nettype none

module rrts_power_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       releaseReq,
   input  wire logic       portResetHigh,
   input  wire logic [7:0] strapUp,
   input  wire logic [7:0] testPointOut,
   input  wire logic [7:0] testPointOe,
   output logic            powerOnResetN,
   output logic            testPortResetN,
   output logic [7:0]      testPointIn
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] stableCnt_reg;

   // ----------------------------------------
   // reset source
   // ----------------------------------------
   // hold until stable
   always_ff @(posedge clk) begin
      if (rst) begin
         stableCnt_reg <= 4'h0;
         powerOnResetN <= 1'b0;
      end else begin
         if (stableCnt_reg != 4'h8) begin
            stableCnt_reg <= stableCnt_reg + 4'h1;
         end
         powerOnResetN <= releaseReq && (stableCnt_reg == 4'h8);
      end
   end

   assign testPortResetN = portResetHigh;

   // ----------------------------------------
   // test point wires
   // ----------------------------------------
   // weak pull-down, optional pull-up
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         testPointIn[i] = testPointOe[i] ? testPointOut[i] : strapUp[i];
      end
   end
endmodule // rrts_power_model

`default_nettype wire

// >>> tb/test_reset_release_test_strap.sv
// testbench of the reset release and strap block
// assumes rrts_defs.svh on the include path and the power model
`include "rrts_defs.svh"
`default_nettype none

module test_reset_release_test_strap
   import rrts_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clk = 1'b0, rst = 1'b1, releaseReq = 1'b0, portResetHigh = 1'b0;
   logic       powerOnResetN, testPortResetN, configStart, configBusy;
   logic       testModeActive, testPortAlarm;
   logic [7:0] strapUp = 8'h00, testObs = 8'h00, testPointIn, testPointOut;
   logic [7:0] testPointOe, testModeSel;
   int         err_count = 0, check_count = 0, cycles = 0;

   always #10 clk = ~clk;

   rrts_power_model u_model (.clk(clk), .rst(rst), .releaseReq(releaseReq),
      .portResetHigh(portResetHigh), .strapUp(strapUp), .testPointOut(testPointOut),
      .testPointOe(testPointOe), .powerOnResetN(powerOnResetN),
      .testPortResetN(testPortResetN), .testPointIn(testPointIn));

   rrts_reset_release u_dut (.clk(clk), .rst(rst), .powerOnResetN(powerOnResetN),
      .testPortResetN(testPortResetN), .testPointIn(testPointIn), .testObs(testObs),
      .testPointOut(testPointOut), .testPointOe(testPointOe), .configStart(configStart),
      .configBusy(configBusy), .testModeSel(testModeSel), .testModeActive(testModeActive),
      .testPortAlarm(testPortAlarm));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic print_verdict();
      if (err_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check_quiet();
      check8("oe", 8'h00, testPointOe);
      check8("out", 8'h00, testPointOut);
      check8("sel", 8'h00, testModeSel);
      check8("flags", 8'h00, {3'h0, configStart, configBusy, testModeActive, testPortAlarm, 1'b0});
   endtask

   task automatic wait_start();
      int n;
      n = 0;
      while (configStart !== 1'b1 && n < 30) begin
         step(1);
         n++;
      end
      check8("start", 8'h01, {7'h0, configStart});
      check8("busy", 8'h01, {7'h0, configBusy});
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic hold_low();
      strapUp = 8'hFF;
      portResetHigh = 1'b1;
      step(20);
      check_quiet();
      check8("tristate", 8'h00, testPointOe);
      portResetHigh = 1'b0;
   endtask

   task automatic release_strap(input logic [7:0] strap);
      int n;
      strapUp = strap;
      releaseReq = 1'b1;
      wait_start();
      n = 0;
      while (configBusy === 1'b1 && n < 200) begin
         check8("oe wait", 8'h00, testPointOe);
         step(1);
         n++;
      end
      check8("wait len", 8'(`RRTS_SAMPLE_CYCLES), 8'(n));
      check8("oe run", 8'hFF, testPointOe);
      check8("sel", strap, testModeSel);
      check8("active", {7'h0, strap != 8'h00}, {7'h0, testModeActive});
      testObs = 8'h3C;
      step(2);
      check8("drive", 8'h3C, testPointOut);
      check8("wire", 8'h3C, testPointIn);
      testObs = 8'hC3;
      step(2);
      check8("drive", 8'hC3, testPointOut);
   endtask

   task automatic release_glitch();
      int n;
      n = 0;
      releaseReq = 1'b1;
      step(1);
      releaseReq = 1'b0;
      repeat (10) begin
         step(1);
         if (configStart !== 1'b0 || configBusy !== 1'b0) begin
            n++;
         end
      end
      check8("glitch start", 8'h00, 8'(n));
      check_quiet();
   endtask

   task automatic abort_wait();
      strapUp = 8'h81;
      releaseReq = 1'b1;
      wait_start();
      step(10);
      releaseReq = 1'b0;
      step(8);
      check_quiet();
      step(100);
      check_quiet();
   endtask

   task automatic port_alarm_and_drop();
      portResetHigh = 1'b1;
      step(8);
      check8("alarm", 8'h01, {7'h0, testPortAlarm});
      portResetHigh = 1'b0;
      releaseReq = 1'b0;
      step(8);
      check_quiet();
   endtask

   // ----------------------------------------
   // main sequence and timeout
   // ----------------------------------------
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         print_verdict();
      end
   end

   initial begin
      step(4);
      rst = 1'b0;
      hold_low();
      release_glitch();
      release_strap(8'hA5);
      port_alarm_and_drop();
      abort_wait();
      release_strap(8'h00);
      port_alarm_and_drop();
      print_verdict();
   end
endmodule // test_reset_release_test_strap

`default_nettype wire
